// ---- core/tmr8_pkg.sv ----
// shared constants and types of the 8-bit waveform timer
package tmr8_pkg;
  localparam logic [7:0] MAX_C    = 8'hFF;
  localparam logic [7:0] BOTTOM_C = 8'h00;

  localparam int         ADDR_W      = 6;
  localparam logic [5:0] REG_CTRL    = 6'h00;
  localparam logic [5:0] REG_COUNT   = 6'h04;
  localparam logic [5:0] REG_CMPA    = 6'h08;
  localparam logic [5:0] REG_CMPB    = 6'h0C;
  localparam logic [5:0] REG_FLAGS   = 6'h10;
  localparam logic [5:0] REG_DIR     = 6'h14;

  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_ACTA_LSB = 4;
  localparam int CTRL_ACTB_LSB = 6;
  localparam int CTRL_CS_LSB   = 8;
  localparam int FLAG_OVF_BIT  = 0;
  localparam int FLAG_MFA_BIT  = 1;
  localparam int FLAG_MFB_BIT  = 2;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam logic [1:0] ACT_OFF    = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR  = 2'h2;
  localparam logic [1:0] ACT_SET    = 2'h3;

  localparam logic [2:0] CS_STOP    = 3'h0;
  localparam logic [2:0] CS_DIV1    = 3'h1;
  localparam logic [2:0] CS_DIV8    = 3'h2;
  localparam logic [2:0] CS_DIV64   = 3'h3;
  localparam logic [2:0] CS_DIV256  = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [9:0] LIM_DIV1    = 10'h000;
  localparam logic [9:0] LIM_DIV8    = 10'h007;
  localparam logic [9:0] LIM_DIV64   = 10'h03F;
  localparam logic [9:0] LIM_DIV256  = 10'h0FF;
  localparam logic [9:0] LIM_DIV1024 = 10'h3FF;

  localparam logic [2:0]  RST_MODE = 3'h0;
  localparam logic [7:0]  RST_BYTE = 8'h00;

  typedef enum logic [2:0] {
    MODE_NORMAL  = 3'b000,
    MODE_PC_FF   = 3'b001,
    MODE_CTC     = 3'b010,
    MODE_FAST_FF = 3'b011,
    MODE_RSV4    = 3'b100,
    MODE_PC_A    = 3'b101,
    MODE_RSV6    = 3'b110,
    MODE_FAST_A  = 3'b111
  } tmr8_mode_t;

  typedef enum logic [1:0] {
    CLS_PLAIN = 2'b00,
    CLS_FAST  = 2'b01,
    CLS_PHASE = 2'b10,
    CLS_NONE  = 2'b11
  } tmr8_cls_t;
endpackage : tmr8_pkg

// ---- core/tmr8_presc.sv ----
// prescaler making the timer clock enable from the io clock
`timescale 1ns/1ps
module tmr8_presc (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [2:0] sel_i,
  output logic            tick_o
);
  logic [9:0] cnt_ff;
  logic [9:0] lim;

  always_comb begin
    unique case (sel_i)
      tmr8_pkg::CS_DIV1:    lim = tmr8_pkg::LIM_DIV1;
      tmr8_pkg::CS_DIV8:    lim = tmr8_pkg::LIM_DIV8;
      tmr8_pkg::CS_DIV64:   lim = tmr8_pkg::LIM_DIV64;
      tmr8_pkg::CS_DIV256:  lim = tmr8_pkg::LIM_DIV256;
      tmr8_pkg::CS_DIV1024: lim = tmr8_pkg::LIM_DIV1024;
      default:              lim = tmr8_pkg::LIM_DIV1;
    endcase
  end

  // stop and unused selects give no enable at all
  always_ff @(posedge clk_i) begin
    if (rst_i || sel_i == tmr8_pkg::CS_STOP || sel_i > tmr8_pkg::CS_DIV1024) begin
      cnt_ff <= 10'h000;
      tick_o <= 1'b0;
    end else if (cnt_ff >= lim) begin
      cnt_ff <= 10'h000;
      tick_o <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 10'h001;
      tick_o <= 1'b0;
    end
  end

  a_div8_spacing: assert property (@(posedge clk_i) disable iff (rst_i)
    (tick_o && sel_i == 3'h2) |=> (!tick_o || sel_i != 3'h2) [*7])
    else $error("divide by 8 enable came early");
endmodule : tmr8_presc

// ---- core/tmr8_wave.sv ----
// compare output unit for one waveform output
`timescale 1ns/1ps
module tmr8_wave (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                tick_i,
  input  wire logic                match_i,
  input  wire logic                wrap_i,
  input  wire logic                up_i,
  input  wire logic                cmp_top_i,
  input  wire tmr8_pkg::tmr8_cls_t cls_i,
  input  wire logic [1:0]          act_i,
  input  wire logic                tgl_ok_i,
  output logic                     wave_o
);
  logic nxt_wave;

  always_comb begin
    nxt_wave = wave_o;
    unique case (cls_i)
      tmr8_pkg::CLS_PLAIN: begin
        if (match_i && act_i == tmr8_pkg::ACT_TOGGLE) nxt_wave = ~wave_o;
        else if (match_i && act_i[1]) nxt_wave = act_i[0];
      end
      tmr8_pkg::CLS_FAST: begin
        if (act_i == tmr8_pkg::ACT_TOGGLE) begin
          if (match_i && tgl_ok_i) nxt_wave = ~wave_o;
        end else if (act_i[1]) begin
          if (wrap_i) nxt_wave = ~act_i[0];
          else if (match_i && !cmp_top_i) nxt_wave = act_i[0];
        end
      end
      tmr8_pkg::CLS_PHASE: begin
        if (act_i == tmr8_pkg::ACT_TOGGLE) begin
          if (match_i && tgl_ok_i) nxt_wave = ~wave_o;
        end else if (act_i[1] && match_i) begin
          // a match at top acts as the falling slope, keeping symmetry
          nxt_wave = (up_i && !cmp_top_i) ? act_i[0] : ~act_i[0];
        end
      end
      tmr8_pkg::CLS_NONE: nxt_wave = wave_o;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) wave_o <= 1'b0;
    else if (tick_i) wave_o <= nxt_wave;
  end

  a_fast_bottom: assert property (@(posedge clk_i) disable iff (rst_i)
    (tick_i && cls_i == tmr8_pkg::CLS_FAST && act_i == 2'h2 && wrap_i) |=> wave_o)
    else $error("non-inverting fast output not set at bottom");
  a_phase_up: assert property (@(posedge clk_i) disable iff (rst_i)
    (tick_i && cls_i == tmr8_pkg::CLS_PHASE && act_i == 2'h2 && match_i && up_i
     && !cmp_top_i) |=> !wave_o)
    else $error("phase output not cleared on rising match");
endmodule : tmr8_wave

// ---- core/tmr8_top.sv ----
// 8-bit timer with waveform modes and an axi4-lite register slave
`timescale 1ns/1ps
module tmr8_top (
  input  wire logic        CLOCK_I,
  input  wire logic        RST_I,
  input  wire logic [5:0]  AWADDR_I,
  input  wire logic        AWVALID_I,
  output logic             AWREADY_O,
  input  wire logic [31:0] WDATA_I,
  input  wire logic [3:0]  WSTRB_I,
  input  wire logic        WVALID_I,
  output logic             WREADY_O,
  output logic [1:0]       BRESP_O,
  output logic             BVALID_O,
  input  wire logic        BREADY_I,
  input  wire logic [5:0]  ARADDR_I,
  input  wire logic        ARVALID_I,
  output logic             ARREADY_O,
  output logic [31:0]      RDATA_O,
  output logic [1:0]       RRESP_O,
  output logic             RVALID_O,
  input  wire logic        RREADY_I,
  input  wire logic        OVF_ACK_I,
  output logic             WAVE_A_O,
  output logic             WAVE_A_OE_N_O,
  output logic             WAVE_B_O,
  output logic             WAVE_B_OE_N_O,
  output logic             OVF_FLAG_O,
  output logic             MATCH_A_FLAG_O,
  output logic             MATCH_B_FLAG_O
);
  tmr8_pkg::tmr8_mode_t mode_ff;
  logic [1:0]           act_a_ff;
  logic [1:0]           act_b_ff;
  logic [2:0]           cs_ff;
  logic [7:0]           cnt_ff;
  logic [7:0]           cmpa_ff;
  logic [7:0]           cmpb_ff;
  logic [7:0]           cmpa_act_ff;
  logic [7:0]           cmpb_act_ff;
  logic                 down_ff;
  logic [1:0]           dir_ff;
  logic [5:0]           aw_addr_ff;
  logic [31:0]          w_data_ff;
  logic [3:0]           w_strb_ff;
  logic                 aw_got_ff;
  logic                 w_got_ff;
  logic                 tick;
  tmr8_pkg::tmr8_cls_t  cls;
  logic [7:0]           top_v;
  logic [7:0]           cmpa_use;
  logic [7:0]           cmpb_use;
  logic                 match_a;
  logic                 match_b;
  logic                 at_top;
  logic [7:0]           nxt_cnt;
  logic                 nxt_down;
  logic                 ovf_ev;
  logic                 wr_do;
  logic                 wr_ok;
  logic                 cnt_wr;
  logic                 flag_wr;
  logic [31:0]          rd_data;
  logic                 rd_ok;

  function automatic tmr8_pkg::tmr8_cls_t mode_class(input tmr8_pkg::tmr8_mode_t m);
    unique case (m)
      tmr8_pkg::MODE_NORMAL, tmr8_pkg::MODE_CTC:    mode_class = tmr8_pkg::CLS_PLAIN;
      tmr8_pkg::MODE_FAST_FF, tmr8_pkg::MODE_FAST_A: mode_class = tmr8_pkg::CLS_FAST;
      tmr8_pkg::MODE_PC_FF, tmr8_pkg::MODE_PC_A:    mode_class = tmr8_pkg::CLS_PHASE;
      tmr8_pkg::MODE_RSV4, tmr8_pkg::MODE_RSV6:     mode_class = tmr8_pkg::CLS_NONE;
    endcase
  endfunction : mode_class

  function automatic logic addr_hit(input logic [5:0] a);
    addr_hit = (a == tmr8_pkg::REG_CTRL) || (a == tmr8_pkg::REG_COUNT)
            || (a == tmr8_pkg::REG_CMPA) || (a == tmr8_pkg::REG_CMPB)
            || (a == tmr8_pkg::REG_FLAGS) || (a == tmr8_pkg::REG_DIR);
  endfunction : addr_hit

  tmr8_presc u_presc (
    .clk_i  (CLOCK_I),
    .rst_i  (RST_I),
    .sel_i  (cs_ff),
    .tick_o (tick)
  );

  // ---- write channel: address and data taken in either order
  assign wr_do   = aw_got_ff && w_got_ff && !BVALID_O;
  assign wr_ok   = addr_hit(aw_addr_ff);
  assign cnt_wr  = wr_do && aw_addr_ff == tmr8_pkg::REG_COUNT && w_strb_ff[0];
  assign flag_wr = wr_do && aw_addr_ff == tmr8_pkg::REG_FLAGS && w_strb_ff[0];

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      AWREADY_O  <= 1'b0;
      aw_got_ff  <= 1'b0;
      aw_addr_ff <= 6'h00;
    end else begin
      AWREADY_O <= AWVALID_I && !AWREADY_O && !aw_got_ff && !BVALID_O;
      if (AWVALID_I && AWREADY_O) begin
        aw_got_ff  <= 1'b1;
        aw_addr_ff <= AWADDR_I;
      end else if (wr_do) begin
        aw_got_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      WREADY_O  <= 1'b0;
      w_got_ff  <= 1'b0;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
    end else begin
      WREADY_O <= WVALID_I && !WREADY_O && !w_got_ff && !BVALID_O;
      if (WVALID_I && WREADY_O) begin
        w_got_ff  <= 1'b1;
        w_data_ff <= WDATA_I;
        w_strb_ff <= WSTRB_I;
      end else if (wr_do) begin
        w_got_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      BVALID_O <= 1'b0;
      BRESP_O  <= tmr8_pkg::RESP_OKAY;
    end else if (wr_do) begin
      BVALID_O <= 1'b1;
      BRESP_O  <= wr_ok ? tmr8_pkg::RESP_OKAY : tmr8_pkg::RESP_SLVERR;
    end else if (BREADY_I) begin
      BVALID_O <= 1'b0;
    end
  end

  // ---- configuration registers
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      mode_ff  <= tmr8_pkg::tmr8_mode_t'(tmr8_pkg::RST_MODE);
      act_a_ff <= tmr8_pkg::ACT_OFF;
      act_b_ff <= tmr8_pkg::ACT_OFF;
      cs_ff    <= tmr8_pkg::CS_STOP;
      cmpa_ff  <= tmr8_pkg::RST_BYTE;
      cmpb_ff  <= tmr8_pkg::RST_BYTE;
      dir_ff   <= 2'h0;
    end else if (wr_do) begin
      if (aw_addr_ff == tmr8_pkg::REG_CTRL && w_strb_ff[0]) begin
        mode_ff  <= tmr8_pkg::tmr8_mode_t'(w_data_ff[tmr8_pkg::CTRL_MODE_LSB +: 3]);
        act_a_ff <= w_data_ff[tmr8_pkg::CTRL_ACTA_LSB +: 2];
        act_b_ff <= w_data_ff[tmr8_pkg::CTRL_ACTB_LSB +: 2];
      end
      if (aw_addr_ff == tmr8_pkg::REG_CTRL && w_strb_ff[1])
        cs_ff <= w_data_ff[tmr8_pkg::CTRL_CS_LSB +: 3];
      if (aw_addr_ff == tmr8_pkg::REG_CMPA && w_strb_ff[0]) cmpa_ff <= w_data_ff[7:0];
      if (aw_addr_ff == tmr8_pkg::REG_CMPB && w_strb_ff[0]) cmpb_ff <= w_data_ff[7:0];
      if (aw_addr_ff == tmr8_pkg::REG_DIR && w_strb_ff[0]) dir_ff <= w_data_ff[1:0];
    end
  end

  // ---- read channel
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_ok   = 1'b1;
    case (ARADDR_I)
      tmr8_pkg::REG_CTRL: begin
        rd_data[tmr8_pkg::CTRL_MODE_LSB +: 3] = mode_ff;
        rd_data[tmr8_pkg::CTRL_ACTA_LSB +: 2] = act_a_ff;
        rd_data[tmr8_pkg::CTRL_ACTB_LSB +: 2] = act_b_ff;
        rd_data[tmr8_pkg::CTRL_CS_LSB +: 3]   = cs_ff;
      end
      tmr8_pkg::REG_COUNT: rd_data[7:0] = cnt_ff;
      tmr8_pkg::REG_CMPA:  rd_data[7:0] = cmpa_ff;
      tmr8_pkg::REG_CMPB:  rd_data[7:0] = cmpb_ff;
      tmr8_pkg::REG_FLAGS: begin
        rd_data[tmr8_pkg::FLAG_OVF_BIT] = OVF_FLAG_O;
        rd_data[tmr8_pkg::FLAG_MFA_BIT] = MATCH_A_FLAG_O;
        rd_data[tmr8_pkg::FLAG_MFB_BIT] = MATCH_B_FLAG_O;
      end
      tmr8_pkg::REG_DIR:   rd_data[1:0] = dir_ff;
      default:             rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      ARREADY_O <= 1'b0;
      RVALID_O  <= 1'b0;
      RDATA_O   <= 32'h0000_0000;
      RRESP_O   <= tmr8_pkg::RESP_OKAY;
    end else begin
      ARREADY_O <= ARVALID_I && !ARREADY_O && !RVALID_O;
      if (ARVALID_I && ARREADY_O) begin
        RVALID_O <= 1'b1;
        RDATA_O  <= rd_data;
        RRESP_O  <= rd_ok ? tmr8_pkg::RESP_OKAY : tmr8_pkg::RESP_SLVERR;
      end else if (RREADY_I) begin
        RVALID_O <= 1'b0;
      end
    end
  end

  // ---- counting sequence
  assign cls      = mode_class(mode_ff);
  // ctc reads compare a live; pwm modes use the buffered copy
  assign cmpa_use = (cls == tmr8_pkg::CLS_PLAIN) ? cmpa_ff : cmpa_act_ff;
  assign cmpb_use = (cls == tmr8_pkg::CLS_PLAIN) ? cmpb_ff : cmpb_act_ff;
  assign top_v    = (mode_ff == tmr8_pkg::MODE_CTC) ? cmpa_ff
                  : (mode_ff[2] ? cmpa_act_ff : tmr8_pkg::MAX_C);
  assign match_a  = cnt_ff == cmpa_use;
  assign match_b  = cnt_ff == cmpb_use;
  assign at_top   = cnt_ff == top_v;

  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_down = down_ff;
    ovf_ev   = 1'b0;
    unique case (mode_ff)
      tmr8_pkg::MODE_NORMAL: begin
        nxt_cnt = cnt_ff + 8'h01;
        ovf_ev  = cnt_ff == tmr8_pkg::MAX_C;
      end
      tmr8_pkg::MODE_CTC: begin
        // a compare written below the count is passed by until the wrap
        nxt_cnt = match_a ? tmr8_pkg::BOTTOM_C : cnt_ff + 8'h01;
        ovf_ev  = cnt_ff == tmr8_pkg::MAX_C;
      end
      tmr8_pkg::MODE_FAST_FF, tmr8_pkg::MODE_FAST_A: begin
        nxt_cnt = at_top ? tmr8_pkg::BOTTOM_C : cnt_ff + 8'h01;
        ovf_ev  = at_top;
      end
      tmr8_pkg::MODE_PC_FF, tmr8_pkg::MODE_PC_A: begin
        if (top_v == tmr8_pkg::BOTTOM_C) begin
          nxt_cnt  = tmr8_pkg::BOTTOM_C;
          nxt_down = 1'b0;
          ovf_ev   = 1'b1;
        end else if (!down_ff) begin
          nxt_down = at_top;
          nxt_cnt  = at_top ? cnt_ff - 8'h01 : cnt_ff + 8'h01;
        end else if (cnt_ff == tmr8_pkg::BOTTOM_C) begin
          nxt_down = 1'b0;
          nxt_cnt  = cnt_ff + 8'h01;
          ovf_ev   = 1'b1;
        end else begin
          nxt_cnt = cnt_ff - 8'h01;
        end
      end
      tmr8_pkg::MODE_RSV4, tmr8_pkg::MODE_RSV6: nxt_cnt = cnt_ff;
    endcase
  end

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      cnt_ff  <= tmr8_pkg::BOTTOM_C;
      down_ff <= 1'b0;
    end else if (cnt_wr) begin
      cnt_ff <= w_data_ff[7:0];
    end else if (tick) begin
      cnt_ff  <= nxt_cnt;
      down_ff <= nxt_down;
    end
  end

  // buffered compares load at top; for mode 7 that is the step to bottom
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      cmpa_act_ff <= tmr8_pkg::RST_BYTE;
      cmpb_act_ff <= tmr8_pkg::RST_BYTE;
    end else if (cls == tmr8_pkg::CLS_PLAIN || cls == tmr8_pkg::CLS_NONE
                 || (tick && at_top)) begin
      cmpa_act_ff <= cmpa_ff;
      cmpb_act_ff <= cmpb_ff;
    end
  end

  // ---- sticky flags: a new event beats a clear in the same cycle
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      OVF_FLAG_O     <= 1'b0;
      MATCH_A_FLAG_O <= 1'b0;
      MATCH_B_FLAG_O <= 1'b0;
    end else begin
      OVF_FLAG_O <= (tick && ovf_ev) || (OVF_FLAG_O && !OVF_ACK_I
                    && !(flag_wr && w_data_ff[tmr8_pkg::FLAG_OVF_BIT]));
      MATCH_A_FLAG_O <= (tick && match_a) || (MATCH_A_FLAG_O
                        && !(flag_wr && w_data_ff[tmr8_pkg::FLAG_MFA_BIT]));
      MATCH_B_FLAG_O <= (tick && match_b) || (MATCH_B_FLAG_O
                        && !(flag_wr && w_data_ff[tmr8_pkg::FLAG_MFB_BIT]));
    end
  end

  // ---- waveform outputs and pin enables
  tmr8_wave u_wave_a (
    .clk_i     (CLOCK_I),
    .rst_i     (RST_I),
    .tick_i    (tick),
    .match_i   (match_a),
    .wrap_i    (at_top),
    .up_i      (!down_ff),
    .cmp_top_i (cmpa_use == top_v),
    .cls_i     (cls),
    .act_i     (act_a_ff),
    .tgl_ok_i  (mode_ff[2]),
    .wave_o    (WAVE_A_O)
  );

  tmr8_wave u_wave_b (
    .clk_i     (CLOCK_I),
    .rst_i     (RST_I),
    .tick_i    (tick),
    .match_i   (match_b),
    .wrap_i    (at_top),
    .up_i      (!down_ff),
    .cmp_top_i (cmpb_use == top_v),
    .cls_i     (cls),
    .act_i     (act_b_ff),
    .tgl_ok_i  (1'b0),
    .wave_o    (WAVE_B_O)
  );

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      WAVE_A_OE_N_O <= 1'b1;
      WAVE_B_OE_N_O <= 1'b1;
    end else begin
      WAVE_A_OE_N_O <= !(dir_ff[0] && act_a_ff != tmr8_pkg::ACT_OFF);
      WAVE_B_OE_N_O <= !(dir_ff[1] && act_b_ff != tmr8_pkg::ACT_OFF);
    end
  end

  // ---- checks
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);

  a_normal_wrap: assert property ((mode_ff == tmr8_pkg::MODE_NORMAL && tick
    && cnt_ff == 8'hFF && !cnt_wr) |=> (cnt_ff == 8'h00 && OVF_FLAG_O))
    else $error("normal mode did not wrap with overflow");
  a_ovf_ack: assert property ((OVF_ACK_I && !(tick && ovf_ev)) |=> !OVF_FLAG_O)
    else $error("overflow flag not cleared by acknowledge");
  a_count_write: assert property (cnt_wr |=> cnt_ff == $past(w_data_ff[7:0]))
    else $error("counter write not taken");
  a_ctc_clear: assert property ((mode_ff == tmr8_pkg::MODE_CTC && tick && match_a
    && !cnt_wr) |=> (cnt_ff == 8'h00 && MATCH_A_FLAG_O))
    else $error("ctc match did not clear counter and set flag");
  a_fast_top: assert property ((cls == tmr8_pkg::CLS_FAST && tick && at_top
    && !cnt_wr) |=> (cnt_ff == 8'h00 && OVF_FLAG_O))
    else $error("fast pwm did not restart at bottom");
  a_phase_turn: assert property ((cls == tmr8_pkg::CLS_PHASE && tick && !down_ff
    && at_top && top_v != 8'h00 && !cnt_wr) |=> (down_ff && cnt_ff == $past(cnt_ff) - 8'h01))
    else $error("phase pwm did not reverse at top");
  a_phase_ovf: assert property ((cls == tmr8_pkg::CLS_PHASE && tick && down_ff
    && cnt_ff == 8'h00) |=> OVF_FLAG_O)
    else $error("phase pwm overflow missing at bottom");
  a_hold_still: assert property ((!tick && !cnt_wr) |=> $stable(cnt_ff))
    else $error("counter moved without timer enable");
  a_pin_off: assert property ((!dir_ff[0]) |=> WAVE_A_OE_N_O)
    else $error("pin a driven while direction is input");
  a_b_no_toggle: assert property ((cls != tmr8_pkg::CLS_PLAIN && act_b_ff == 2'h1
    && tick) |=> $stable(WAVE_B_O))
    else $error("output b toggled in a pwm mode");
endmodule : tmr8_top

// ---- testbench/timer8_waveform_modes_tb.sv ----
// self-checking bench for the 8-bit waveform timer
`timescale 1ns/1ps
module timer8_waveform_modes_tb;
  logic        clk, rst, awv, wv, bre, arv, rre, ack;
  logic [5:0]  awa, ara;
  logic [31:0] wd;
  logic [3:0]  ws;
  wire  logic  awr, wr_o, bv, arr, rv, wa, wa_n, wb, wb_n, ovf, mfa, mfb;
  wire  logic [1:0]  br, rr;
  wire  logic [31:0] rd_o;
  int          fails, n_compared;
  logic [31:0] rdat;
  logic [1:0]  rrsp;
  logic [1:0]  wrsp;

  tmr8_top tmr8_top_i (.CLOCK_I(clk), .RST_I(rst), .AWADDR_I(awa), .AWVALID_I(awv),
    .AWREADY_O(awr), .WDATA_I(wd), .WSTRB_I(ws), .WVALID_I(wv), .WREADY_O(wr_o),
    .BRESP_O(br), .BVALID_O(bv), .BREADY_I(bre), .ARADDR_I(ara), .ARVALID_I(arv),
    .ARREADY_O(arr), .RDATA_O(rd_o), .RRESP_O(rr), .RVALID_O(rv), .RREADY_I(rre),
    .OVF_ACK_I(ack), .WAVE_A_O(wa), .WAVE_A_OE_N_O(wa_n), .WAVE_B_O(wb),
    .WAVE_B_OE_N_O(wb_n), .OVF_FLAG_O(ovf), .MATCH_A_FLAG_O(mfa), .MATCH_B_FLAG_O(mfb));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic give_verdict;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic hang;
    fails++;
    give_verdict();
  endtask : hang

  // master holds each valid until its own ready edge
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    int k;
    awa <= a; wd <= d; ws <= 4'hF; awv <= 1'b1; wv <= 1'b1; bre <= 1'b1;
    for (k = 0; k < 50 && !(bv === 1'b1); k++) begin
      @(posedge clk);
      if (awr === 1'b1) awv <= 1'b0;
      if (wr_o === 1'b1) wv <= 1'b0;
      wrsp = br;
    end
    if (k >= 50) hang();
    bre <= 1'b0;
    // idle edge so a following call never re-drives a signal in one step
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [5:0] a);
    int k;
    ara <= a; arv <= 1'b1; rre <= 1'b1;
    for (k = 0; k < 50 && !(rv === 1'b1); k++) begin
      @(posedge clk);
      if (arr === 1'b1) arv <= 1'b0;
      rdat = rd_o;
      rrsp = rr;
    end
    if (k >= 50) hang();
    rre <= 1'b0;
    @(posedge clk);
  endtask : rd

  // cycles up to the next rising edge of output a
  task automatic rise(output int n);
    logic p;
    p = wa;
    for (n = 1; n <= 5000; n++) begin
      @(posedge clk);
      if (p === 1'b0 && wa === 1'b1) return;
      p = wa;
    end
    hang();
  endtask : rise

  task automatic period(input logic [31:0] ctrl, input int exp);
    int n;
    wr(tmr8_pkg::REG_CTRL, ctrl);
    rise(n);
    rise(n);
    chk(n, exp);
  endtask : period

  task automatic t_reset;
    rd(tmr8_pkg::REG_CTRL);
    chk(rdat, 32'h0000_0000);
    rd(tmr8_pkg::REG_FLAGS);
    chk(rdat, 32'h0000_0000);
    rd(6'h18);
    chk(rrsp, tmr8_pkg::RESP_SLVERR);
    wr(6'h18, 32'h0000_0000);
    chk(wrsp, tmr8_pkg::RESP_SLVERR);
    chk(wa_n, 1'b1);
    chk(wb_n, 1'b1);
    chk(wb, 1'b0);
    $display("reset test done");
  endtask : t_reset

  task automatic t_normal;
    int n;
    wr(tmr8_pkg::REG_CTRL, 32'h0000_0100);
    wr(tmr8_pkg::REG_COUNT, 32'h0000_00F0);
    for (n = 0; n < 40 && !(ovf === 1'b1); n++) @(posedge clk);
    chk(n >= 12 && n <= 18, 1'b1);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    repeat (2) @(posedge clk);
    chk(ovf, 1'b0);
    $display("normal test done");
  endtask : t_normal

  task automatic t_ctc;
    logic a0;
    wr(tmr8_pkg::REG_DIR, 32'h0000_0003);
    wr(tmr8_pkg::REG_CMPA, 32'h0000_0000);
    wr(tmr8_pkg::REG_CTRL, 32'h0000_01D2);
    // compare below the count is passed by, so the count keeps rising
    wr(tmr8_pkg::REG_COUNT, 32'h0000_0010);
    rd(tmr8_pkg::REG_COUNT);
    chk(rdat[7:0] > 8'h10, 1'b1);
    wr(tmr8_pkg::REG_COUNT, 32'h0000_0000);
    repeat (3) @(posedge clk);
    a0 = wa;
    @(posedge clk);
    chk(a0 ^ wa, 1'b1);
    chk(mfa, 1'b1);
    chk(wa_n, 1'b0);
    chk(wb, 1'b1);
    chk(wb_n, 1'b0);
    chk(mfb, 1'b1);
    $display("ctc test done");
  endtask : t_ctc

  task automatic t_pwm;
    logic a0;
    logic b0;
    int k, ch;
    wr(tmr8_pkg::REG_CMPA, 32'h0000_0080);
    period(32'h0000_0123, 256);
    period(32'h0000_0121, 510);
    period(32'h0000_0223, 2048);
    // toggle is refused while the high mode bit is clear
    wr(tmr8_pkg::REG_CTRL, 32'h0000_0153);
    a0 = wa;
    b0 = wb;
    ch = 0;
    for (k = 0; k < 600; k++) begin
      @(posedge clk);
      if (wa !== a0) ch++;
    end
    chk(ch, 0);
    chk(wb, b0);
    // with the high mode bit set output a toggles at top 0x80
    period(32'h0000_0157, 258);
    chk(wb, b0);
    $display("pwm test done");
  endtask : t_pwm

  initial begin
    fails = 0; n_compared = 0;
    rst = 1'b1; awv = 1'b0; wv = 1'b0; bre = 1'b0; arv = 1'b0; rre = 1'b0; ack = 1'b0;
    awa = 6'h00; ara = 6'h00; wd = 32'h0000_0000; ws = 4'h0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_normal();
    t_ctc();
    t_pwm();
    give_verdict();
  end
endmodule : timer8_waveform_modes_tb
